// ==== src/gmsk_bitstream_front_end.sv ====
// Top level of the GMSK bit stream front end with its register slave
// Function
// - Polarity bit flips the deviation sense of every modulated bit.
// - Degraded fidelity adds a random phase error of up to ten degrees.
// - Differential encoding applied when enabled, bits passed raw otherwise.
// - Continuous envelope holds amplitude at full scale always.
// - Shaped envelope with external data follows the envelope input linearly.
// - Shaped envelope with internal data mutes outside active slots and in null slots.
// - Settings stores 0 to 19 for save and restore; other indices refused.
// - Stores hold modulation controls only, never carrier or level.
// - Full store keeps modulation mode but not the settings stores.
// - External mode locks the generator reference to the bit clock.
// - Absent bit clock raises lock error 06 or missing clock error 43.
// - Either clock format is detected and locked without configuration.
// - Long period gives a phase step warning three bits ahead of it.
// - Digital mode drives the data connector as low frequency output.
// - Channels 1 to 124 and 512 to 885 accepted, others rejected.
// - Channel sets uplink or downlink carrier by the entry used.
// - Digital mode makes extended level hysteresis unavailable.
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module gmsk_bitstream_front_end
    import gmsk_fe_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DEF,
    parameter int unsigned GSM_UP_KHZ = 0,
    parameter int unsigned GSM_DN_KHZ = 0,
    parameter int unsigned PCN_UP_KHZ = 0,
    parameter int unsigned PCN_DN_KHZ = 0,
    parameter int unsigned STEP_KHZ = 1
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // External bit stream link
    input wire logic ext_bit_clk,
    input wire logic ext_data_in,
    // Internal data generator
    input wire logic int_bit,
    input wire logic int_bit_strobe,
    input wire logic burst_start,
    input wire logic slot_active,
    input wire logic null_slot,
    // Envelope level, full scale is +1 V
    input wire logic [7:0] env_level,
    // Low frequency output on the data connector
    input wire logic lf_bit,
    output logic lf_pin_out,
    output logic lf_pin_oe,
    // Modulator side
    output logic mod_bit,
    output logic mod_strobe,
    output logic [7:0] phase_offset,
    output logic [7:0] amplitude,
    output logic phase_jump,
    output logic gen_ref_locked,
    output logic hysteresis_avail
);
    // Channel number inside an inclusive span
    function automatic logic in_span(input logic [CHAN_W-1:0] n,
        input logic [CHAN_W-1:0] lo, input logic [CHAN_W-1:0] hi);
        return (n >= lo) && (n <= hi);
    endfunction : in_span

    logic [CTRL_W-1:0] ctrl;
    logic [STORE_W-1:0] store_mem [NUM_STORES];
    logic full_mode;
    logic store_refused;
    logic chan_rejected;
    logic [CHAN_W-1:0] chan_num;
    logic chan_down;
    logic [31:0] carrier_khz;
    logic [31:0] rd_mux;
    logic [31:0] next_carrier;
    logic [31:0] base_khz;
    logic [CHAN_W-1:0] first_chan;
    logic prev_bit;
    logic [15:0] lfsr;
    logic [4:0] ph_raw;
    logic [7:0] next_phase;
    logic in_bit;
    logic in_strobe;
    logic enc_bit;
    logic [7:0] err_code;

    bit_link_if lnk ();

    // Register writes take effect when the bus sees waitrequest low
    wire wr_ok = avs_write && !avs_waitrequest;
    wire wr_ctrl = wr_ok && avs_address == REG_CTRL;
    wire wr_store = wr_ok && avs_address == REG_STORE;
    wire wr_chan = wr_ok && avs_address == REG_CHANNEL;
    wire wr_full = wr_ok && avs_address == REG_FULL;
    wire [IDX_W-1:0] st_idx = avs_writedata[IDX_W-1:0];
    wire idx_ok = st_idx < NUM_STORES;
    wire [CHAN_W-1:0] wch = avs_writedata[CHAN_W-1:0];
    wire gsm_ok = in_span(wch, GSM_FIRST, GSM_LAST);
    wire pcn_ok = in_span(wch, PCN_FIRST, PCN_LAST);

    bit_clock_tracker #(
        .BIT_CYC(BIT_CYC)
    ) u_tracker (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .ext_bit_clk(ext_bit_clk),
        .ext_data_in(ext_data_in),
        .ext_mode(ctrl[C_EXT]),
        .lnk(lnk.tracker)
    );

    // Bus handshake: one wait cycle, then a one-cycle answer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
        end
    end

    // Error code shown in status, missing clock takes priority
    always_comb begin
        err_code = 8'h00;
        if (lnk.clk_missing) begin
            err_code = ERR_NO_CLK;
        end else if (lnk.lock_lost) begin
            err_code = ERR_LOCK;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl;
            REG_STATUS: begin
                rd_mux[S_LOCKED] = lnk.locked;
                rd_mux[S_CONT] = lnk.fmt_cont;
                rd_mux[S_LONG] = lnk.fmt_long;
                rd_mux[S_LOCK_ERR] = lnk.lock_lost;
                rd_mux[S_NO_CLK] = lnk.clk_missing;
                rd_mux[S_ST_REF] = store_refused;
                rd_mux[S_CH_REJ] = chan_rejected;
                rd_mux[S_CODE +: 8] = err_code;
            end
            REG_CHANNEL: begin
                rd_mux[CHAN_W-1:0] = chan_num;
                rd_mux[CH_DOWN] = chan_down;
            end
            REG_CARRIER: rd_mux = carrier_khz;
            REG_FULL: rd_mux[FULL_SAVE] = full_mode;
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data captured in the wait cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (ce && avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // Control register, restored settings and recalled mode
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= avs_writedata[CTRL_W-1:0];
            end else if (wr_store && avs_writedata[ST_RESTORE] && idx_ok) begin
                ctrl[STORE_W-1:0] <= store_mem[st_idx];
            end else if (wr_full && avs_writedata[FULL_RECALL]) begin
                ctrl[C_MODE] <= full_mode;
            end
        end
    end

    // Settings stores hold modulation controls only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < int'(NUM_STORES); i++) begin
                store_mem[i] <= CTRL_RESET[STORE_W-1:0];
            end
        end else if (ce && wr_store && avs_writedata[ST_SAVE] && idx_ok) begin
            store_mem[st_idx] <= ctrl[STORE_W-1:0];
        end
    end

    // Store command outcome
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            store_refused <= 1'b0;
        end else if (ce && wr_store && (avs_writedata[ST_SAVE] || avs_writedata[ST_RESTORE])) begin
            store_refused <= !idx_ok;
        end
    end

    // Full store keeps the mode selection only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            full_mode <= 1'b0;
        end else if (ce && wr_full && avs_writedata[FULL_SAVE]) begin
            full_mode <= ctrl[C_MODE];
        end
    end

    // Carrier from channel number, band and direction
    always_comb begin
        first_chan = gsm_ok ? GSM_FIRST : PCN_FIRST;
        if (gsm_ok) begin
            base_khz = avs_writedata[CH_DOWN] ? GSM_DN_KHZ : GSM_UP_KHZ;
        end else begin
            base_khz = avs_writedata[CH_DOWN] ? PCN_DN_KHZ : PCN_UP_KHZ;
        end
        next_carrier = base_khz + 32'(STEP_KHZ * 32'(wch - first_chan));
    end

    // Channel entry
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            chan_num <= '0;
            chan_down <= 1'b0;
            carrier_khz <= 32'h0;
            chan_rejected <= 1'b0;
        end else if (ce && wr_chan) begin
            chan_rejected <= !(gsm_ok || pcn_ok);
            if (gsm_ok || pcn_ok) begin
                chan_num <= wch;
                chan_down <= avs_writedata[CH_DOWN];
                carrier_khz <= next_carrier;
            end
        end
    end

    // Source selection and differential encoding
    always_comb begin
        in_bit = ctrl[C_EXT] ? lnk.bit_val : int_bit;
        in_strobe = ctrl[C_EXT] ? lnk.bit_strobe : int_bit_strobe;
        enc_bit = ctrl[C_DIFF] ? (in_bit ^ (prev_bit & !burst_start)) : in_bit;
    end

    // Modulated bit with sense applied
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prev_bit <= 1'b0;
            mod_bit <= 1'b0;
            mod_strobe <= 1'b0;
        end else if (ce) begin
            mod_strobe <= in_strobe;
            if (in_strobe) begin
                prev_bit <= in_bit;
                mod_bit <= enc_bit ^ ctrl[C_SENSE];
            end else if (burst_start) begin
                prev_bit <= 1'b0;
            end
        end
    end

    // Phase error over plus and minus the peak, values from minus the peak to zero twice as likely
    always_comb begin
        ph_raw = lfsr[4:0];
        if (ph_raw > (PHASE_PEAK << 1)) begin
            ph_raw = ph_raw - (PHASE_PEAK << 1) - 5'h01;
        end
        next_phase = {3'h0, ph_raw} - {3'h0, PHASE_PEAK};
    end

    // Degraded fidelity phase error, new value per bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lfsr <= LFSR_SEED;
            phase_offset <= 8'h00;
        end else if (ce) begin
            if (in_strobe) begin
                lfsr <= {lfsr[14:0], ^(lfsr & LFSR_TAPS)};
            end
            phase_offset <= ctrl[C_DEGRADE] ? next_phase : 8'h00;
        end
    end

    // Envelope control
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            amplitude <= AMP_FULL;
        end else if (ce) begin
            if (!ctrl[C_SHAPED]) begin
                amplitude <= AMP_FULL;
            end else if (ctrl[C_EXT]) begin
                amplitude <= env_level;
            end else if (!slot_active || null_slot) begin
                amplitude <= 8'h00;
            end else begin
                amplitude <= AMP_FULL;
            end
        end
    end

    // Mode dependent outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lf_pin_out <= 1'b0;
            lf_pin_oe <= 1'b0;
            hysteresis_avail <= 1'b1;
            gen_ref_locked <= 1'b0;
            phase_jump <= 1'b0;
        end else if (ce) begin
            lf_pin_out <= lf_bit;
            lf_pin_oe <= ctrl[C_MODE];
            hysteresis_avail <= !ctrl[C_MODE];
            gen_ref_locked <= ctrl[C_EXT] && lnk.locked;
            phase_jump <= ctrl[C_EXT] && lnk.phase_jump;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_bus_req;
        ce && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_bus_ans;
        !avs_waitrequest;
    endsequence

    a_bus_answer: assert property (s_bus_req |=> s_bus_ans)
        else $error("bus request not answered after one wait cycle");
    a_amp_constant: assert property (ce && !ctrl[C_SHAPED] |=> amplitude == AMP_FULL)
        else $error("continuous envelope not at full scale");
    a_env_follow: assert property (ce && ctrl[C_SHAPED] && ctrl[C_EXT]
        |=> amplitude == $past(env_level))
        else $error("amplitude does not follow envelope input");
    a_slot_mute: assert property (ce && ctrl[C_SHAPED] && !ctrl[C_EXT] && null_slot
        |=> amplitude == 8'h00)
        else $error("null slot not suppressed");
    a_diff_code: assert property (ce && in_strobe && ctrl[C_DIFF] && !burst_start
        |=> mod_bit == ($past(in_bit) ^ $past(prev_bit) ^ $past(ctrl[C_SENSE])))
        else $error("differential encoding wrong");
    a_store_refuse: assert property (ce && wr_store && avs_writedata[ST_SAVE]
        && !idx_ok |=> store_refused)
        else $error("out of range store index not refused");
    a_chan_reject: assert property (ce && wr_chan && !gsm_ok && !pcn_ok
        |=> chan_rejected && $stable(carrier_khz))
        else $error("bad channel number accepted");
    a_lf_drive: assert property (ce ##1 ce |-> lf_pin_oe == $past(ctrl[C_MODE])
        && hysteresis_avail == !$past(ctrl[C_MODE]))
        else $error("low frequency output or hysteresis wrong for mode");
    a_phase_bound: assert property (ce && ctrl[C_DEGRADE] |=>
        $signed(phase_offset) <= 8'sd10 && $signed(phase_offset) >= -8'sd10)
        else $error("phase error out of bound");
endmodule : gmsk_bitstream_front_end
`default_nettype wire

// ==== src/gmsk_fe_pkg.sv ====
// Shared constants for the GMSK bit stream front end
package gmsk_fe_pkg;
    // Timing
    localparam int SYS_HZ = 50_000_000;
    localparam int BIT_RATE_HZ = 270_833;
    localparam int BIT_CYC_DEF = SYS_HZ / BIT_RATE_HZ;
    localparam int LONG_NUM = 5;
    localparam int LONG_DEN = 4;
    localparam int MISS_MULT = 4;
    localparam int CNT_W = 10;
    localparam logic [3:0] LOCK_PERIODS = 4'h8;
    localparam logic [7:0] SHORT_RUN = 8'd155;
    localparam logic [7:0] DISC_LEAD = 8'h03;
    localparam logic [7:0] JUMP_AT = SHORT_RUN - DISC_LEAD - 8'h01;
    localparam logic [7:0] CONT_RUN = SHORT_RUN + 8'h08;
    // Register map, byte addresses
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_STORE = 5'h08;
    localparam logic [ADDR_W-1:0] REG_CHANNEL = 5'h0c;
    localparam logic [ADDR_W-1:0] REG_CARRIER = 5'h10;
    localparam logic [ADDR_W-1:0] REG_FULL = 5'h14;
    // Control fields
    localparam int CTRL_W = 6;
    localparam int STORE_W = 5;
    localparam int C_SENSE = 0;
    localparam int C_DEGRADE = 1;
    localparam int C_DIFF = 2;
    localparam int C_SHAPED = 3;
    localparam int C_EXT = 4;
    localparam int C_MODE = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h04;
    // Status fields
    localparam int S_LOCKED = 0;
    localparam int S_CONT = 1;
    localparam int S_LONG = 2;
    localparam int S_LOCK_ERR = 3;
    localparam int S_NO_CLK = 4;
    localparam int S_ST_REF = 5;
    localparam int S_CH_REJ = 6;
    localparam int S_CODE = 8;
    localparam logic [7:0] ERR_LOCK = 8'h06;
    localparam logic [7:0] ERR_NO_CLK = 8'h2b;
    // Store, full store and channel fields
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] NUM_STORES = 5'h14;
    localparam int ST_SAVE = 8;
    localparam int ST_RESTORE = 9;
    localparam int FULL_SAVE = 0;
    localparam int FULL_RECALL = 1;
    localparam int CHAN_W = 10;
    localparam int CH_DOWN = 16;
    localparam logic [CHAN_W-1:0] GSM_FIRST = 10'd1;
    localparam logic [CHAN_W-1:0] GSM_LAST = 10'd124;
    localparam logic [CHAN_W-1:0] PCN_FIRST = 10'd512;
    localparam logic [CHAN_W-1:0] PCN_LAST = 10'd885;
    // Envelope and phase error
    localparam logic [7:0] AMP_FULL = 8'hff;
    localparam logic [4:0] PHASE_PEAK = 5'd10;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
endpackage : gmsk_fe_pkg

// ==== src/bit_link_if.sv ====
// Bit clock tracker results handed to the front end core
`timescale 1ns/1ns
`default_nettype none
interface bit_link_if;
    logic bit_strobe;
    logic bit_val;
    logic locked;
    logic lock_lost;
    logic clk_missing;
    logic fmt_cont;
    logic fmt_long;
    logic phase_jump;
    modport tracker (output bit_strobe, bit_val, locked, lock_lost, clk_missing,
        fmt_cont, fmt_long, phase_jump);
    modport core (input bit_strobe, bit_val, locked, lock_lost, clk_missing,
        fmt_cont, fmt_long, phase_jump);
endinterface : bit_link_if
`default_nettype wire

// ==== src/bit_clock_tracker.sv ====
// Samples the external bit stream and tracks its clock format and lock
`timescale 1ns/1ns
`default_nettype none
module bit_clock_tracker
    import gmsk_fe_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYC_DEF
) (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    // Link pins
    input wire logic ext_bit_clk,
    input wire logic ext_data_in,
    // External data mode
    input wire logic ext_mode,
    // Results
    bit_link_if.tracker lnk
);
    localparam int LONG_CYC = BIT_CYC * LONG_NUM / LONG_DEN;
    localparam logic [CNT_W-1:0] SHORT_MIN = CNT_W'(BIT_CYC - BIT_CYC / 8);
    localparam logic [CNT_W-1:0] LONG_MAX = CNT_W'(LONG_CYC + BIT_CYC / 8);
    localparam logic [CNT_W-1:0] SPLIT = CNT_W'((BIT_CYC + LONG_CYC) / 2);
    localparam logic [CNT_W-1:0] MISS_CNT = CNT_W'(BIT_CYC * MISS_MULT);

    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_prev;
    logic [CNT_W-1:0] period;
    logic [7:0] run;
    logic [3:0] good;
    wire fall = clk_prev & ~clk_sync[1];
    wire is_long = period >= SPLIT;
    wire in_range = (period >= SHORT_MIN) && (period <= LONG_MAX);

    // Two-stage synchronisers for the link pins
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_sync <= 2'h0;
            dat_sync <= 2'h0;
            clk_prev <= 1'b0;
        end else if (ce) begin
            clk_sync <= {clk_sync[0], ext_bit_clk};
            dat_sync <= {dat_sync[0], ext_data_in};
            clk_prev <= clk_sync[1];
        end
    end

    // Sample data on the falling clock edge and time each period
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lnk.bit_strobe <= 1'b0;
            lnk.bit_val <= 1'b0;
            period <= '0;
            lnk.clk_missing <= 1'b0;
        end else if (ce) begin
            lnk.bit_strobe <= fall & ext_mode;
            if (fall) begin
                lnk.bit_val <= dat_sync[1];
                period <= CNT_W'(1);
            end else if (period != MISS_CNT) begin
                period <= period + CNT_W'(1);
            end
            lnk.clk_missing <= ext_mode && (period == MISS_CNT);
        end
    end

    // Lock after a run of plausible periods
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            good <= 4'h0;
            lnk.locked <= 1'b0;
            lnk.lock_lost <= 1'b0;
        end else if (ce) begin
            if (!ext_mode || period == MISS_CNT) begin
                good <= 4'h0;
            end else if (fall) begin
                good <= !in_range ? 4'h0 : (good == LOCK_PERIODS) ? good : good + 4'h1;
            end
            lnk.locked <= ext_mode && (good == LOCK_PERIODS);
            lnk.lock_lost <= ext_mode && (good != LOCK_PERIODS);
        end
    end

    // Format detection and phase step warning ahead of a long period
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run <= 8'h0;
            lnk.fmt_cont <= 1'b0;
            lnk.fmt_long <= 1'b0;
            lnk.phase_jump <= 1'b0;
        end else if (ce) begin
            lnk.phase_jump <= fall && lnk.fmt_long && !is_long && run == JUMP_AT;
            if (fall && in_range) begin
                if (is_long) begin
                    lnk.fmt_long <= (run == SHORT_RUN);
                    lnk.fmt_cont <= 1'b0;
                    run <= 8'h0;
                end else if (run != CONT_RUN) begin
                    run <= run + 8'h1;
                end else begin
                    lnk.fmt_cont <= 1'b1;
                    lnk.fmt_long <= 1'b0;
                end
            end
        end
    end

    a_long_detect: assert property (@(posedge sys_clk) disable iff (rst)
        ce && fall && in_range && is_long && run == SHORT_RUN |=> lnk.fmt_long)
        else $error("long period format not detected");
    a_miss_detect: assert property (@(posedge sys_clk) disable iff (rst)
        ce && ext_mode && period == MISS_CNT |=> lnk.clk_missing)
        else $error("missing bit clock not flagged");
endmodule : bit_clock_tracker
`default_nettype wire

// ==== bench/bit_src.sv ====
// Serial data and bit clock source that feeds the front end link pins
`timescale 1ns/1ns
`default_nettype none
module bit_src (
    // Control
    input wire logic run,
    input wire logic long_fmt,
    // Link pins
    output logic bclk,
    output logic bdat
);
    logic [7:0] cnt;
    logic [7:0] per;
    // Clock runs at 160 ns only while enabled; data moves on the rising edge
    initial begin
        cnt = 8'h00;
        per = 8'h00;
        bclk = 1'b0;
        bdat = 1'b0;
        forever begin
            #80;
            if (run) begin
                bclk = ~bclk;
                if (bclk) begin
                    cnt = cnt + 8'h01;
                    bdat = cnt[0] ^ cnt[2];
                    if (long_fmt && per == 8'h9b) begin
                        per = 8'h00;
                        #40;
                    end else begin
                        per = long_fmt ? per + 8'h01 : 8'h00;
                    end
                end
            end else begin
                bclk = 1'b0;
                bdat = ~bdat; // Released line never shows a stale bit
            end
        end
    end
endmodule : bit_src
`default_nettype wire

// ==== bench/gmsk_bitstream_front_end_tb_top.sv ====
// Self-checking bench for the GMSK bit stream front end
`timescale 1ns/1ns
`default_nettype none
module gmsk_bitstream_front_end_tb_top;
    import gmsk_fe_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] adr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = '0;
    logic [31:0] rdata;
    logic wait_req;
    logic run = 1'b0;
    logic int_bit = 1'b0, int_strobe = 1'b0, burst = 1'b0, null_on = 1'b0, fall_dat = 1'b0;
    logic slot_on = 1'b1, long_fmt = 1'b0;
    logic bclk, bdat, lf_pin_out, lf_pin_oe, mod_bit, mod_strobe, phase_jump, locked, hyst;
    logic [7:0] env_level = 8'h00;
    logic lf_bit = 1'b0;
    logic [7:0] phase_offset, amplitude;
    logic [31:0] q;
    int error_cnt = 0;
    int n_tests = 0;
    // Clock
    always #10 sys_clk = ~sys_clk;
    // Bit the source holds at each falling clock edge
    always @(negedge bclk) fall_dat = bdat;
    bit_src src (.run(run), .long_fmt(long_fmt), .bclk(bclk), .bdat(bdat));
    gmsk_bitstream_front_end #(.BIT_CYC(8), .GSM_UP_KHZ(1000), .PCN_DN_KHZ(2000),
        .STEP_KHZ(200)) dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .ext_bit_clk(bclk), .ext_data_in(bdat), .int_bit(int_bit),
        .int_bit_strobe(int_strobe), .burst_start(burst), .slot_active(slot_on),
        .null_slot(null_on),
        .env_level(env_level), .lf_bit(lf_bit), .lf_pin_out(lf_pin_out), .lf_pin_oe(lf_pin_oe),
        .mod_bit(mod_bit), .mod_strobe(mod_strobe), .phase_offset(phase_offset),
        .amplitude(amplitude), .phase_jump(phase_jump), .gen_ref_locked(locked),
        .hysteresis_avail(hyst));
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= ~w;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (wait_req !== 1'b0 && i < 50);
        if (i >= 50) begin
            error_cnt++;
            end_of_test();
        end
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge sys_clk);
    endtask : bus
    task automatic t_regs();
        chk(amplitude, 8'hff);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h04);
        bus(1'b1, REG_CTRL, 32'h0b);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h0b);
        chk(32'($signed(phase_offset) > 10 || $signed(phase_offset) < -10), 32'h0);
        bus(1'b0, 5'h18, 32'h0);
        chk(q, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_store();
        bus(1'b1, REG_STORE, 32'h113);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[S_ST_REF], 1'b0);
        bus(1'b1, REG_CTRL, 32'h0);
        @(posedge sys_clk);
        chk(phase_offset, 8'h00);
        bus(1'b1, REG_STORE, 32'h213);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h0b);
        bus(1'b1, REG_STORE, 32'h114);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[S_ST_REF], 1'b1);
        bus(1'b1, REG_CTRL, 32'h20);
        bus(1'b1, REG_FULL, 32'h1);
        bus(1'b1, REG_CTRL, 32'h0);
        bus(1'b1, REG_FULL, 32'h2);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h20);
        $display("t_store done");
    endtask : t_store
    task automatic t_chan();
        bus(1'b1, REG_CHANNEL, 32'h1_0258);
        bus(1'b0, REG_CARRIER, 32'h0);
        chk(q, 32'h4c90);
        bus(1'b1, REG_CHANNEL, 32'd125);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[S_CH_REJ], 1'b1);
        bus(1'b1, REG_CHANNEL, 32'd3);
        bus(1'b0, REG_CARRIER, 32'h0);
        chk(q, 32'h578);
        $display("t_chan done");
    endtask : t_chan
    task automatic t_ext();
        int i;
        bus(1'b1, REG_CTRL, 32'h38);
        run <= 1'b1;
        repeat (20) @(posedge sys_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[15:8], ERR_LOCK);
        for (i = 0; i < 400 && locked !== 1'b1; i++) @(posedge sys_clk);
        chk(locked, 1'b1);
        repeat (2) begin
            for (i = 0; i < 20 && mod_strobe !== 1'b1; i++) @(posedge sys_clk);
            chk({mod_strobe, mod_bit}, {1'b1, fall_dat});
            @(posedge sys_clk);
        end
        chk(hyst, 1'b0);
        chk(lf_pin_oe, 1'b1);
        lf_bit <= 1'b1;
        env_level <= 8'h40;
        repeat (3) @(posedge sys_clk);
        chk(lf_pin_out, 1'b1);
        chk(amplitude, 8'h40);
        run <= 1'b0;
        repeat (80) @(posedge sys_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[15:8], ERR_NO_CLK);
        $display("t_ext done");
    endtask : t_ext
    // One internal bit with optional burst start, judged once it stands
    task automatic send_int(input logic b, input logic s, input logic e);
        int_bit <= b;
        burst <= s;
        int_strobe <= 1'b1;
        @(posedge sys_clk);
        burst <= 1'b0;
        int_strobe <= 1'b0;
        @(posedge sys_clk);
        chk(mod_bit, e);
    endtask : send_int
    task automatic t_int();
        bus(1'b1, REG_CTRL, 32'h0d);
        send_int(1'b1, 1'b1, 1'b0);
        send_int(1'b1, 1'b0, 1'b1);
        send_int(1'b1, 1'b1, 1'b0);
        bus(1'b1, REG_CTRL, 32'h08);
        send_int(1'b1, 1'b0, 1'b1);
        null_on <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(amplitude, 8'h00);
        null_on <= 1'b0;
        slot_on <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(amplitude, 8'h00);
        slot_on <= 1'b1;
        $display("t_int done");
    endtask : t_int
    task automatic t_long();
        int i;
        long_fmt <= 1'b1;
        run <= 1'b1;
        for (i = 0; i < 5000 && phase_jump !== 1'b1; i++) @(posedge sys_clk);
        chk(phase_jump, 1'b1);
        long_fmt <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[2:0], 3'h5);
        repeat (300) @(posedge sys_clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk(q[2:0], 3'h3);
        $display("t_long done");
    endtask : t_long
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_regs();
        t_store();
        t_chan();
        t_int();
        t_ext();
        t_long();
        end_of_test();
    end
endmodule : gmsk_bitstream_front_end_tb_top
`default_nettype wire
